// >>> core/clkdet_dsp_pkg.sv
/*
  Constants for the clock-detection status and DSP configuration register slice:
  register offsets, reset values, field positions, encodings and detector limits.
  Assumes the control port presents byte-wide registers at 8-bit offsets.
*/
// Notes on behaviour
// - Auto rate mode: bit 0 flags invalid rate
// - Fixed rate mode: bit 0 flags rate mismatch
// - Ignore setting never masks the rate flag
// - Bit 1: bit clock stable, 32 to 512
// - Bit 2 flags a missing bit clock
// - Bit 3 PLL lock, unlocked when disabled
// - Bit 4 flags PLL overrate
// - Bit 5 flags bit clock overrate
// - Program code 0 RAM, 1-3 ROM programs
// - Program select resets to 0x01
// - Coefficient bit: 1 ROM, 0 host download
package clkdet_dsp_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] CLOCK_DETECT_FLAGS_OFFSET = 8'h39;
    localparam logic [7:0] DSP_PROGRAM_SELECT_OFFSET = 8'h40;
    localparam logic [7:0] DSP_CONTROL_OFFSET = 8'h46;
    localparam logic [7:0] DIGITAL_VOLUME_OFFSET = 8'h4c;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CLOCK_DETECT_FLAGS_RESET = 8'h00;
    localparam logic [7:0] DSP_PROGRAM_SELECT_RESET = 8'h01;
    localparam logic [7:0] DSP_CONTROL_RESET = 8'h01;
    localparam logic [7:0] DIGITAL_VOLUME_RESET = 8'h30;
    localparam logic [7:0] READ_DEFAULT = 8'h00;

    // ----------------------------------------------------------------
    // Field positions and widths
    // ----------------------------------------------------------------
    localparam int FLAG_COUNT = 6;
    localparam int FLAG_FS_ERROR = 0;
    localparam int FLAG_SCLK_VALID = 1;
    localparam int FLAG_SCLK_MISSING = 2;
    localparam int FLAG_PLL_LOCKED = 3;
    localparam int FLAG_PLL_OVERRATE = 4;
    localparam int FLAG_SCLK_OVERRATE = 5;
    localparam int PROGRAM_WIDTH = 5;
    localparam int CTRL_RATE_LSB = 3;
    localparam int CTRL_RATE_MSB = 4;
    localparam int CTRL_COEF_BIT = 0;
    localparam logic [7:0] CLOCK_DETECT_WRITE_MASK = 8'hc0;
    localparam logic [7:0] DSP_CONTROL_WRITE_MASK = 8'hf9;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    localparam logic [3:0] FS_MODE_AUTO = 4'h0;
    localparam logic [3:0] FS_CODE_ERROR = 4'h0;
    localparam logic [4:0] PROGRAM_RAM = 5'h00;
    localparam logic [4:0] PROGRAM_ROM_LAST = 5'h03;
    localparam int SCLK_RATIO_WIDTH = 10;
    localparam logic [9:0] SCLK_RATIO_MIN = 10'h020;
    localparam logic [9:0] SCLK_RATIO_MAX = 10'h200;

    typedef enum logic [1:0] {
        RATE_INPUT = 2'h0,
        RATE_48K = 2'h1,
        RATE_96K = 2'h2,
        RATE_192K = 2'h3
    } processing_rate_type;

endpackage : clkdet_dsp_pkg

// >>> core/clock_detect_if.sv
/*
  Carrier between the register slice and its flag evaluator: detector
  inputs in, six registered status flags out.
  Assumes all signals are synchronous to the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface clock_detect_if;
    import clkdet_dsp_pkg::*;
    logic [3:0] fs_mode;
    logic [3:0] detected_fs;
    logic [SCLK_RATIO_WIDTH-1:0] sclk_ratio;
    logic sclk_ratio_stable;
    logic sclk_missing;
    logic pll_enable;
    logic pll_locked;
    logic pll_overrate;
    logic sclk_overrate;
    logic [FLAG_COUNT-1:0] flags;

    modport source (output fs_mode, detected_fs, sclk_ratio, sclk_ratio_stable, sclk_missing,
                    output pll_enable, pll_locked, pll_overrate, sclk_overrate, input flags);
    modport evaluator (input fs_mode, detected_fs, sclk_ratio, sclk_ratio_stable, sclk_missing,
                       input pll_enable, pll_locked, pll_overrate, sclk_overrate, output flags);
endinterface : clock_detect_if
`default_nettype wire

// >>> core/clock_detect_flags.sv
/*
  Evaluates the live clock-detection flags once per enabled clock.
  Assumes detector inputs are synchronous to clock_i.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_detect_flags (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic enable_i,
    // Detector carrier
    clock_detect_if.evaluator det
);
    import clkdet_dsp_pkg::*;

    // ----------------------------------------------------------------
    // Flag evaluation
    // ----------------------------------------------------------------
    function automatic logic ratio_in_range(input logic [SCLK_RATIO_WIDTH-1:0] ratio);
        ratio_in_range = (ratio >= SCLK_RATIO_MIN) && (ratio <= SCLK_RATIO_MAX);
    endfunction : ratio_in_range

    logic [FLAG_COUNT-1:0] next_flags;
    logic [FLAG_COUNT-1:0] flags;

    always_comb begin
        next_flags = '0;
        // Rate flag is never masked by the ignore setting
        if (det.fs_mode == FS_MODE_AUTO) begin
            next_flags[FLAG_FS_ERROR] = (det.detected_fs == FS_CODE_ERROR);
        end else begin
            next_flags[FLAG_FS_ERROR] = (det.detected_fs != det.fs_mode);
        end
        next_flags[FLAG_SCLK_VALID] = det.sclk_ratio_stable && ratio_in_range(det.sclk_ratio);
        next_flags[FLAG_SCLK_MISSING] = det.sclk_missing;
        next_flags[FLAG_PLL_LOCKED] = det.pll_enable && det.pll_locked;
        next_flags[FLAG_PLL_OVERRATE] = det.pll_overrate;
        next_flags[FLAG_SCLK_OVERRATE] = det.sclk_overrate;
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            flags <= CLOCK_DETECT_FLAGS_RESET[FLAG_COUNT-1:0];
        end else if (enable_i) begin
            flags <= next_flags;
        end
    end

    assign det.flags = flags;

endmodule : clock_detect_flags
`default_nettype wire

// >>> core/clock_detect_dsp_config_regs.sv
/*
  Register slice: clock-detection flags, DSP program select, DSP control
  and digital volume, on a byte-wide control port.
  Assumes a control-port front end that issues one-cycle read and write
  strobes with an 8-bit offset, synchronous to clock_i.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_detect_dsp_config_regs (
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic enable_i,
    // Control port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Detector state
    input wire logic [3:0] fs_mode_i,
    input wire logic [3:0] detected_fs_i,
    input wire logic [clkdet_dsp_pkg::SCLK_RATIO_WIDTH-1:0] sclk_ratio_i,
    input wire logic sclk_ratio_stable_i,
    input wire logic sclk_missing_i,
    input wire logic pll_enable_i,
    input wire logic pll_locked_i,
    input wire logic pll_overrate_i,
    input wire logic sclk_overrate_i,
    // Configuration outputs
    output logic [clkdet_dsp_pkg::PROGRAM_WIDTH-1:0] dsp_program_o,
    output logic ram_program_o,
    output logic rom_program_valid_o,
    output clkdet_dsp_pkg::processing_rate_type processing_rate_o,
    output logic default_coef_select_o,
    output logic [7:0] volume_level_o,
    output logic [clkdet_dsp_pkg::FLAG_COUNT-1:0] clock_detect_flags_o
);
    import clkdet_dsp_pkg::*;

    // ----------------------------------------------------------------
    // Flag evaluator
    // ----------------------------------------------------------------
    // Flags leave flip-flops in the evaluator; the read mux takes them as they stand
    clock_detect_if det ();

    assign det.fs_mode = fs_mode_i;
    assign det.detected_fs = detected_fs_i;
    assign det.sclk_ratio = sclk_ratio_i;
    assign det.sclk_ratio_stable = sclk_ratio_stable_i;
    assign det.sclk_missing = sclk_missing_i;
    assign det.pll_enable = pll_enable_i;
    assign det.pll_locked = pll_locked_i;
    assign det.pll_overrate = pll_overrate_i;
    assign det.sclk_overrate = sclk_overrate_i;

    clock_detect_flags flag_eval (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .enable_i(enable_i),
        .det(det)
    );

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    function automatic logic offset_hit(input logic [7:0] addr, input logic [7:0] offset);
        offset_hit = (addr == offset);
    endfunction : offset_hit

    // Strobes count only while the clock enable is high
    logic write_en;
    logic read_en;
    logic flags_write;
    logic program_write;
    logic control_write;
    logic volume_write;

    assign write_en = enable_i && reg_wr_i;
    assign read_en = enable_i && reg_rd_i;
    assign flags_write = write_en && offset_hit(reg_addr_i, CLOCK_DETECT_FLAGS_OFFSET);
    assign program_write = write_en && offset_hit(reg_addr_i, DSP_PROGRAM_SELECT_OFFSET);
    assign control_write = write_en && offset_hit(reg_addr_i, DSP_CONTROL_OFFSET);
    assign volume_write = write_en && offset_hit(reg_addr_i, DIGITAL_VOLUME_OFFSET);

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [7:0] clock_detect_flags_reg;
    logic [7:0] dsp_program_select;
    logic [7:0] dsp_control;
    logic [7:0] digital_volume_level;

    function automatic logic [7:0] masked_write(input logic [7:0] old_value,
                                                input logic [7:0] new_value,
                                                input logic [7:0] mask);
        masked_write = (old_value & ~mask) | (new_value & mask);
    endfunction : masked_write

    // Only the reserved upper bits are stored; flag bits ignore writes
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            clock_detect_flags_reg <= CLOCK_DETECT_FLAGS_RESET;
        end else if (flags_write) begin
            clock_detect_flags_reg <= masked_write(clock_detect_flags_reg, reg_wdata_i,
                                                   CLOCK_DETECT_WRITE_MASK);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            dsp_program_select <= DSP_PROGRAM_SELECT_RESET;
        end else if (program_write) begin
            dsp_program_select <= reg_wdata_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            dsp_control <= DSP_CONTROL_RESET;
        end else if (control_write) begin
            dsp_control <= masked_write(dsp_control, reg_wdata_i, DSP_CONTROL_WRITE_MASK);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            digital_volume_level <= DIGITAL_VOLUME_RESET;
        end else if (volume_write) begin
            digital_volume_level <= reg_wdata_i;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // A read in the same cycle as a write returns the old value
    logic [7:0] next_rdata;

    always_comb begin
        case (reg_addr_i)
            CLOCK_DETECT_FLAGS_OFFSET: begin
                next_rdata = {clock_detect_flags_reg[7:FLAG_COUNT], det.flags};
            end
            DSP_PROGRAM_SELECT_OFFSET: begin
                next_rdata = dsp_program_select;
            end
            DSP_CONTROL_OFFSET: begin
                next_rdata = dsp_control;
            end
            DIGITAL_VOLUME_OFFSET: begin
                next_rdata = digital_volume_level;
            end
            default: begin
                next_rdata = READ_DEFAULT;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= READ_DEFAULT;
        end else if (read_en) begin
            reg_rdata_o <= next_rdata;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            reg_rvalid_o <= 1'b0;
        end else if (enable_i) begin
            reg_rvalid_o <= read_en;
        end
    end

    // ----------------------------------------------------------------
    // Program decode
    // ----------------------------------------------------------------
    function automatic logic is_ram_program(input logic [PROGRAM_WIDTH-1:0] code);
        is_ram_program = (code == PROGRAM_RAM);
    endfunction : is_ram_program

    function automatic logic is_rom_program(input logic [PROGRAM_WIDTH-1:0] code);
        is_rom_program = (code != PROGRAM_RAM) && (code <= PROGRAM_ROM_LAST);
    endfunction : is_rom_program

    // Decoded at the write edge so both flags leave flip-flops together with the code
    logic ram_program;
    logic rom_program_valid;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ram_program <= is_ram_program(DSP_PROGRAM_SELECT_RESET[PROGRAM_WIDTH-1:0]);
            rom_program_valid <= is_rom_program(DSP_PROGRAM_SELECT_RESET[PROGRAM_WIDTH-1:0]);
        end else if (program_write) begin
            ram_program <= is_ram_program(reg_wdata_i[PROGRAM_WIDTH-1:0]);
            rom_program_valid <= is_rom_program(reg_wdata_i[PROGRAM_WIDTH-1:0]);
        end
    end

    // ----------------------------------------------------------------
    // Configuration outputs
    // ----------------------------------------------------------------
    logic [PROGRAM_WIDTH-1:0] program_code;
    logic [1:0] rate_field;
    logic coef_field;

    assign program_code = dsp_program_select[PROGRAM_WIDTH-1:0];
    assign rate_field = dsp_control[CTRL_RATE_MSB:CTRL_RATE_LSB];
    assign coef_field = dsp_control[CTRL_COEF_BIT];

    assign dsp_program_o = program_code;
    assign ram_program_o = ram_program;
    assign rom_program_valid_o = rom_program_valid;
    assign processing_rate_o = processing_rate_type'(rate_field);
    assign default_coef_select_o = coef_field;
    assign volume_level_o = digital_volume_level;
    assign clock_detect_flags_o = det.flags;

endmodule : clock_detect_dsp_config_regs
`default_nettype wire

// >>> sim/clock_detect_dsp_config_regs_asserts.sv
/*
  Port checker for the clock-detection and DSP configuration register slice.
  Assumes it is bound to clock_detect_dsp_config_regs in one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_detect_dsp_config_regs_chk
    import clkdet_dsp_pkg::*;
(
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic enable_i,
    // Control port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    // Detector state
    input wire logic [3:0] fs_mode_i,
    input wire logic [3:0] detected_fs_i,
    input wire logic [clkdet_dsp_pkg::SCLK_RATIO_WIDTH-1:0] sclk_ratio_i,
    input wire logic sclk_ratio_stable_i,
    input wire logic sclk_missing_i,
    input wire logic pll_enable_i,
    input wire logic pll_locked_i,
    input wire logic pll_overrate_i,
    input wire logic sclk_overrate_i,
    // Configuration outputs
    input wire logic [clkdet_dsp_pkg::PROGRAM_WIDTH-1:0] dsp_program_o,
    input wire logic ram_program_o,
    input wire logic rom_program_valid_o,
    input wire clkdet_dsp_pkg::processing_rate_type processing_rate_o,
    input wire logic default_coef_select_o,
    input wire logic [clkdet_dsp_pkg::FLAG_COUNT-1:0] clock_detect_flags_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    sequence prog_write;
        enable_i && reg_wr_i && reg_addr_i == 8'h40;
    endsequence
    sequence ctrl_write;
        enable_i && reg_wr_i && reg_addr_i == 8'h46;
    endsequence

    AST_FS_AUTO: assert property (enable_i && fs_mode_i == 4'h0 |=>
        clock_detect_flags_o[0] == $past(detected_fs_i == 4'h0)) else $error("rate flag wrong in auto mode");
    AST_FS_FIXED: assert property (enable_i && fs_mode_i != 4'h0 |=>
        clock_detect_flags_o[0] == $past(detected_fs_i != fs_mode_i)) else $error("rate flag wrong in fixed mode");
    AST_SCLK_VALID: assert property (enable_i |=> clock_detect_flags_o[1] ==
        $past(sclk_ratio_stable_i && sclk_ratio_i >= 10'h020 && sclk_ratio_i <= 10'h200)) else $error("bit clock valid");
    AST_SCLK_MISSING: assert property (enable_i |=>
        clock_detect_flags_o[2] == $past(sclk_missing_i)) else $error("bit clock missing flag wrong");
    AST_PLL_LOCK: assert property (enable_i |=>
        clock_detect_flags_o[3] == $past(pll_enable_i && pll_locked_i)) else $error("pll lock flag wrong");
    AST_OVERRATE: assert property (enable_i |=>
        clock_detect_flags_o[5:4] == $past({sclk_overrate_i, pll_overrate_i})) else $error("overrate flags wrong");
    AST_FLAGS_HOLD: assert property (!enable_i |=> $stable(clock_detect_flags_o))
        else $error("flags moved while disabled");
    AST_PROG_WRITE: assert property (prog_write |=> dsp_program_o == $past(reg_wdata_i[4:0]))
        else $error("program select write lost");
    AST_PROG_DECODE: assert property (ram_program_o == (dsp_program_o == 5'h00)
        && rom_program_valid_o == (dsp_program_o >= 5'h01 && dsp_program_o <= 5'h03)) else $error("program decode");
    AST_CTRL_WRITE: assert property (ctrl_write |=> processing_rate_o == $past(reg_wdata_i[4:3])
        && default_coef_select_o == $past(reg_wdata_i[0])) else $error("control write lost");
endmodule : clock_detect_dsp_config_regs_chk

bind clock_detect_dsp_config_regs clock_detect_dsp_config_regs_chk u_chk (.clock_i, .rst_n_i, .enable_i,
    .reg_addr_i, .reg_wr_i, .reg_wdata_i, .fs_mode_i, .detected_fs_i, .sclk_ratio_i, .sclk_ratio_stable_i,
    .sclk_missing_i, .pll_enable_i, .pll_locked_i, .pll_overrate_i, .sclk_overrate_i, .dsp_program_o,
    .ram_program_o, .rom_program_valid_o, .processing_rate_o, .default_coef_select_o, .clock_detect_flags_o);
`default_nettype wire

// >>> sim/clock_detect_dsp_config_regs_tb.sv
/*
  Self-checking bench for the register slice.
  Assumes the package, design and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_detect_dsp_config_regs_tb;
    import clkdet_dsp_pkg::*;
    logic clock_i, rst_n_i, enable_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, volume_level_o, d;
    logic [3:0] fs_mode_i, detected_fs_i;
    logic [9:0] sclk_ratio_i;
    logic sclk_ratio_stable_i, sclk_missing_i, pll_enable_i, pll_locked_i, pll_overrate_i, sclk_overrate_i;
    logic [4:0] dsp_program_o;
    logic ram_program_o, rom_program_valid_o, default_coef_select_o;
    processing_rate_type processing_rate_o;
    logic [5:0] clock_detect_flags_o, f;
    logic [9:0] corner [4] = '{10'h01f, 10'h020, 10'h200, 10'h201};
    int bad_count, n_checks;

    clock_detect_dsp_config_regs u_clock_detect_dsp_config_regs (.clock_i, .rst_n_i, .enable_i, .reg_addr_i,
        .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .fs_mode_i, .detected_fs_i,
        .sclk_ratio_i, .sclk_ratio_stable_i, .sclk_missing_i, .pll_enable_i, .pll_locked_i, .pll_overrate_i,
        .sclk_overrate_i, .dsp_program_o, .ram_program_o, .rom_program_valid_o, .processing_rate_o,
        .default_coef_select_o, .volume_level_o, .clock_detect_flags_o);

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function logic [5:0] exp_flags();
        logic e;
        e = (fs_mode_i == 4'h0) ? (detected_fs_i == 4'h0) : (detected_fs_i != fs_mode_i);
        return {sclk_overrate_i, pll_overrate_i, pll_enable_i & pll_locked_i, sclk_missing_i,
                sclk_ratio_stable_i && sclk_ratio_i >= 10'd32 && sclk_ratio_i <= 10'd512, e};
    endfunction : exp_flags

    task summarize();
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", n, e, g);
            bad_count++;
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1;
        chk("rvalid", 8'h01, {7'h00, reg_rvalid_o});
        chk("rdata", e, reg_rdata_o);
    endtask : rd

    initial begin
        #400000;
        bad_count++;
        summarize();
    end

    initial begin
        {rst_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, fs_mode_i, detected_fs_i, sclk_ratio_i} = '0;
        {sclk_ratio_stable_i, sclk_missing_i, pll_enable_i, pll_locked_i, pll_overrate_i, sclk_overrate_i} = '0;
        enable_i = 1'b1;
        void'($urandom(32'hc628));
        repeat (5) @(posedge clock_i);
        #1;
        chk("flags_rst", 8'h00, {2'b00, clock_detect_flags_o});
        chk("prog_rst", 8'h01, {3'b000, dsp_program_o});
        chk("ctrl_rst", 8'h01, {3'b000, processing_rate_o, 2'b00, default_coef_select_o});
        rst_n_i <= 1'b1;
        rd(8'h40, 8'h01);
        rd(8'h46, 8'h01);
        rd(8'h4c, 8'h30);
        rd(8'h50, 8'h00);
        for (int i = 0; i < 5; i++) begin
            d = {3'($urandom), (i == 4) ? 5'h1f : 5'(i)};
            wr(8'h40, d);
            chk("prog", {3'b000, d[4:0]}, {3'b000, dsp_program_o});
            chk("ram_rom", {6'h00, d[4:0] == 5'h00, d[4:0] >= 5'h01 && d[4:0] <= 5'h03},
                {6'h00, ram_program_o, rom_program_valid_o});
            rd(8'h40, d);
        end
        for (int i = 0; i < 8; i++) begin
            d = {3'($urandom), 2'(i >> 1), 2'($urandom), 1'(i)};
            wr(8'h46, d);
            chk("ctrl", {5'h00, d[4:3], d[0]}, {5'h00, processing_rate_o, default_coef_select_o});
            rd(8'h46, d & 8'hf9);
        end
        d = 8'($urandom);
        wr(8'h4c, d);
        chk("volume", d, volume_level_o);
        enable_i <= 1'b0;
        sclk_missing_i <= 1'b1;
        wr(8'h40, 8'h02);
        chk("prog_frozen", 8'h1f, {3'b000, dsp_program_o});
        chk("flags_frozen", 8'h01, {2'b00, clock_detect_flags_o});
        enable_i <= 1'b1;
        for (int i = 0; i < 60; i++) begin
            @(posedge clock_i);
            d = 8'($urandom);
            fs_mode_i <= (i % 3 == 0) ? 4'h0 : d[3:0];
            detected_fs_i <= (i % 5 == 0) ? 4'h0 : ((i % 2 == 0) ? d[3:0] : d[7:4]);
            sclk_ratio_i <= (i < 4) ? corner[i] : 10'($urandom);
            {sclk_ratio_stable_i, sclk_missing_i, pll_enable_i, pll_locked_i, pll_overrate_i, sclk_overrate_i}
                <= 6'($urandom) | ((i < 4) ? 6'h20 : 6'h00);
            @(posedge clock_i);
            #1;
            f = exp_flags();
            chk("flags", {2'b00, f}, {2'b00, clock_detect_flags_o});
        end
        rd(8'h39, {2'b00, f});
        wr(8'h39, 8'hff);
        rd(8'h39, {2'b11, f});
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        enable_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        #1;
        chk("flags_rst2", 8'h00, {2'b00, clock_detect_flags_o});
        chk("prog_rst2", 8'h01, {6'h00, ram_program_o, rom_program_valid_o});
        chk("vol_rst2", 8'h30, volume_level_o);
        @(posedge clock_i);
        rst_n_i <= 1'b1;
        enable_i <= 1'b1;
        rd(8'h39, {2'b00, f});
        rd(8'h40, 8'h01);
        summarize();
    end
endmodule : clock_detect_dsp_config_regs_tb
`default_nettype wire
